// ===== design/mfr_cfg_pkg.sv
// Purpose: Constants for the manufacturer configuration register bank.
// Assumes: Command codes are the bus command bytes of the register bank.
// Notes:   Offsets, register reset values and most field positions live here; the pin code field 3:0 is coded in the module.
package mfr_cfg_pkg;

  // Command codes of the register bank.
  localparam logic [7:0] CMD_VOUT_RB_GAIN   = 8'hd1;
  localparam logic [7:0] CMD_VOUT_RB_OFFSET = 8'hd2;
  localparam logic [7:0] CMD_VIN_RB_GAIN    = 8'hd3;
  localparam logic [7:0] CMD_VIN_RB_OFFSET  = 8'hd4;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_GAIN      = 8'hd6;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_OFFSET    = 8'hd7;
  localparam logic [7:0] CMD_FW_REVISION    = 8'hdb;
  localparam logic [7:0] CMD_ALERT_PIN      = 8'he0;
  localparam logic [7:0] CMD_ONOFF_COMBINE  = 8'he1;
  localparam logic [7:0] CMD_POWER_OK_POL   = 8'he2;
  localparam logic [7:0] CMD_DATE_LOC_SER   = 8'hf0;

  // Gain words: unity is the reset value, with a bounded span.
  localparam logic [15:0] GAIN_RESET = 16'h2000;
  localparam logic [15:0] GAIN_MIN   = 16'h1999;
  localparam logic [15:0] GAIN_MAX   = 16'h2666;
  localparam int          GAIN_FRAC  = 13;

  // Linear-format offset words: exponent in bits 15:11, mantissa in 10:0.
  localparam int         EXP_MSB    = 15;
  localparam int         EXP_LSB    = 11;
  localparam int         MANT_W     = 11;
  localparam logic [4:0] EXP_VOUT   = 5'h14;
  localparam logic [4:0] EXP_VIN    = 5'h1d;
  localparam logic [4:0] EXP_OUTPUT_CURRENT   = 5'h1c;
  localparam logic [MANT_W-1:0] MANT_ZERO = 11'h000;

  // Alert and pin assignment fields.
  localparam int         ARA_BIT       = 4;
  localparam logic [3:0] PIN_ONOFF_PG  = 4'h0;
  localparam logic [3:0] PIN_TRIM_PG   = 4'h1;
  localparam logic [3:0] PIN_TRIM_ONOFF = 4'h2;
  localparam logic [7:0] ALERT_PIN_RESET = 8'h00;

  // On/off combination and power-good polarity fields.
  localparam int         COMB_AND_BIT  = 1;
  localparam int         COMB_POL_BIT  = 0;
  localparam logic [1:0] COMB_RESET    = 2'h0;
  localparam logic       PG_POL_RESET  = 1'b1;

  // Date, location and serial block.
  localparam int         BLK_BYTES     = 12;
  localparam logic [7:0] BLK_COUNT     = 8'h0c;
  localparam logic [95:0] BLK_RESET    = 96'h0;

  // Firmware revision, BCD: major, minor, build high, build low. Value arbitrary.
  localparam logic [15:0] FW_REV_VALUE = 16'h1000;
  localparam logic [3:0]  BCD_MAX      = 4'h9;

endpackage

// ===== design/mfr_cfg_regs.sv
// Purpose: Manufacturer configuration registers of a power module behind a command port.
// Assumes: One request per cycle from command-layer logic on the same clock.
// Notes:   Config pins are asynchronous and pass two flip-flops first.
`timescale 1ns/10ps
`default_nettype none

module mfr_cfg_regs (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [7:0]  req_code_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic [95:0] blk_wdata_i,
  input  wire logic [7:0]  blk_wcount_i,
  input  wire logic        write_protect_bit_i,
  input  wire logic        droop_variant_i,
  input  wire logic        isolated_unit_i,
  input  wire logic [4:0]  designation_low_i,
  input  wire logic        primary_onoff_req_i,
  input  wire logic        power_ok_i,
  input  wire logic [15:0] raw_vout_i,
  input  wire logic [15:0] raw_input_voltage_i,
  input  wire logic [15:0] raw_output_current_i,
  input  wire logic        first_config_pin_i,
  input  wire logic        second_config_pin_i,
  output logic             ack_o,
  output logic             invalid_data_o,
  output logic             invalid_cmd_o,
  output logic [15:0]      rd_data_o,
  output logic [95:0]      blk_rdata_o,
  output logic [7:0]       blk_rcount_o,
  output logic             ara_only_o,
  output logic             first_pin_is_trim_o,
  output logic             second_config_pin_o,
  output logic             second_config_pin_oe_o,
  output logic             output_enable_o,
  output logic [5:0]       module_designation_o,
  output logic [15:0]      cal_vout_o,
  output logic [15:0]      cal_input_voltage_o,
  output logic [15:0]      cal_output_current_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration helper: gain has 13 fraction bits, offset mantissa is signed.

  function automatic logic [15:0] calibrate(input logic [15:0] raw,
                                            input logic [15:0] gain,
                                            input logic [15:0] offs);
    logic [31:0] prod;
    logic [15:0] offs_ext;
    prod     = 32'(raw) * 32'(gain);
    offs_ext = {{(16 - mfr_cfg_pkg::MANT_W){offs[mfr_cfg_pkg::MANT_W-1]}},
                offs[mfr_cfg_pkg::MANT_W-1:0]};
    return 16'(prod >> mfr_cfg_pkg::GAIN_FRAC) + offs_ext;
  endfunction

  function automatic logic gain_ok(input logic [15:0] g);
    return (g >= mfr_cfg_pkg::GAIN_MIN) && (g <= mfr_cfg_pkg::GAIN_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [15:0] vout_readback_gain_reg;
  logic [15:0] vout_readback_offset_reg;
  logic [15:0] vin_readback_gain_reg;
  logic [15:0] vin_readback_offset_reg;
  logic [15:0] output_current_gain_trim_reg;
  logic [15:0] output_current_offset_trim_reg;
  logic [4:0]  alert_and_pin_assign_reg;
  logic [1:0]  onoff_combine_logic_reg;
  logic        power_ok_polarity_reg;
  logic [95:0] module_date_loc_serial_reg;
  logic [1:0]  first_pin_sync_reg;
  logic [1:0]  second_pin_sync_reg;

  logic        wr;
  logic        rd;
  logic        locked;
  logic        known;
  logic        data_ok;
  logic        commit;
  logic [4:0]  wexp;
  logic [3:0]  pin_code;
  logic        pin_ok;
  logic        fw_ok;
  logic [15:0] rd_next;

  assign wr       = req_valid_i && req_write_i;
  assign rd       = req_valid_i && !req_write_i;
  assign wexp     = req_wdata_i[mfr_cfg_pkg::EXP_MSB:mfr_cfg_pkg::EXP_LSB];
  assign locked   = write_protect_bit_i;
  assign pin_code = req_wdata_i[3:0];
  assign pin_ok   = (pin_code == mfr_cfg_pkg::PIN_ONOFF_PG)
                 || (!droop_variant_i && (pin_code == mfr_cfg_pkg::PIN_TRIM_PG
                 || pin_code == mfr_cfg_pkg::PIN_TRIM_ONOFF));

  // A revision with a digit above nine is reported as invalid data on read.
  assign fw_ok = (mfr_cfg_pkg::FW_REV_VALUE[15:12] <= mfr_cfg_pkg::BCD_MAX)
              && (mfr_cfg_pkg::FW_REV_VALUE[11:8] <= mfr_cfg_pkg::BCD_MAX)
              && (mfr_cfg_pkg::FW_REV_VALUE[7:4] <= mfr_cfg_pkg::BCD_MAX)
              && (mfr_cfg_pkg::FW_REV_VALUE[3:0] <= mfr_cfg_pkg::BCD_MAX);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode: whether the code exists and whether a write would be taken.

  always_comb begin
    known   = 1'b1;
    data_ok = 1'b1;
    rd_next = 16'h0000;
    unique case (req_code_i)
      mfr_cfg_pkg::CMD_VOUT_RB_GAIN: begin
        rd_next = vout_readback_gain_reg;
        data_ok = !locked && gain_ok(req_wdata_i);
      end
      mfr_cfg_pkg::CMD_VOUT_RB_OFFSET: begin
        rd_next = vout_readback_offset_reg;
        data_ok = !locked && (wexp == mfr_cfg_pkg::EXP_VOUT);
      end
      mfr_cfg_pkg::CMD_VIN_RB_GAIN: begin
        rd_next = vin_readback_gain_reg;
        data_ok = !locked && gain_ok(req_wdata_i);
      end
      mfr_cfg_pkg::CMD_VIN_RB_OFFSET: begin
        rd_next = vin_readback_offset_reg;
        data_ok = !locked && (wexp == mfr_cfg_pkg::EXP_VIN);
      end
      mfr_cfg_pkg::CMD_OUTPUT_CURRENT_GAIN: begin
        rd_next = output_current_gain_trim_reg;
        data_ok = !locked && gain_ok(req_wdata_i);
      end
      mfr_cfg_pkg::CMD_OUTPUT_CURRENT_OFFSET: begin
        rd_next = output_current_offset_trim_reg;
        data_ok = !locked && (wexp == mfr_cfg_pkg::EXP_OUTPUT_CURRENT);
      end
      mfr_cfg_pkg::CMD_FW_REVISION: begin
        rd_next = mfr_cfg_pkg::FW_REV_VALUE;
        data_ok = fw_ok && !req_write_i;
      end
      mfr_cfg_pkg::CMD_ALERT_PIN: begin
        rd_next = {11'h000, alert_and_pin_assign_reg};
        data_ok = pin_ok && (req_wdata_i[7:5] == 3'h0);
      end
      mfr_cfg_pkg::CMD_ONOFF_COMBINE: begin
        rd_next = {14'h0000, onoff_combine_logic_reg};
      end
      mfr_cfg_pkg::CMD_POWER_OK_POL: begin
        rd_next = {15'h0000, power_ok_polarity_reg};
      end
      mfr_cfg_pkg::CMD_DATE_LOC_SER: begin
        data_ok = !locked && (blk_wcount_i == mfr_cfg_pkg::BLK_COUNT);
      end
      default: begin
        known   = 1'b0;
        data_ok = 1'b0;
      end
    endcase
  end

  // Writes to the read-only revision are refused, never stored.
  assign commit = wr && known && data_ok && (req_code_i != mfr_cfg_pkg::CMD_FW_REVISION);

  ////////////////////////////////////////////////////////////////////////////////
  // Answer: one cycle after the request.

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_o          <= 1'b0;
      invalid_data_o <= 1'b0;
      invalid_cmd_o  <= 1'b0;
    end else begin
      ack_o          <= req_valid_i;
      invalid_cmd_o  <= req_valid_i && !known;
      invalid_data_o <= req_valid_i && known && ((wr && !commit) || (rd && !data_ok
                        && req_code_i == mfr_cfg_pkg::CMD_FW_REVISION));
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_o    <= 16'h0000;
      blk_rdata_o  <= mfr_cfg_pkg::BLK_RESET;
      blk_rcount_o <= 8'h00;
    end else if (rd) begin
      rd_data_o    <= rd_next;
      blk_rdata_o  <= (req_code_i == mfr_cfg_pkg::CMD_DATE_LOC_SER)
                      ? module_date_loc_serial_reg : mfr_cfg_pkg::BLK_RESET;
      blk_rcount_o <= (req_code_i == mfr_cfg_pkg::CMD_DATE_LOC_SER)
                      ? mfr_cfg_pkg::BLK_COUNT : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration words. They hold their value until an accepted write or srst_i changes them.

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      vout_readback_gain_reg   <= mfr_cfg_pkg::GAIN_RESET;
      vout_readback_offset_reg <= {mfr_cfg_pkg::EXP_VOUT, mfr_cfg_pkg::MANT_ZERO};
      vin_readback_gain_reg    <= mfr_cfg_pkg::GAIN_RESET;
      vin_readback_offset_reg  <= {mfr_cfg_pkg::EXP_VIN, mfr_cfg_pkg::MANT_ZERO};
      output_current_gain_trim_reg       <= mfr_cfg_pkg::GAIN_RESET;
      output_current_offset_trim_reg     <= {mfr_cfg_pkg::EXP_OUTPUT_CURRENT, mfr_cfg_pkg::MANT_ZERO};
    end else if (commit) begin
      if (req_code_i == mfr_cfg_pkg::CMD_VOUT_RB_GAIN)
        vout_readback_gain_reg <= req_wdata_i;
      if (req_code_i == mfr_cfg_pkg::CMD_VOUT_RB_OFFSET)
        vout_readback_offset_reg <= req_wdata_i;
      if (req_code_i == mfr_cfg_pkg::CMD_VIN_RB_GAIN)
        vin_readback_gain_reg <= req_wdata_i;
      if (req_code_i == mfr_cfg_pkg::CMD_VIN_RB_OFFSET)
        vin_readback_offset_reg <= req_wdata_i;
      if (req_code_i == mfr_cfg_pkg::CMD_OUTPUT_CURRENT_GAIN)
        output_current_gain_trim_reg <= req_wdata_i;
      if (req_code_i == mfr_cfg_pkg::CMD_OUTPUT_CURRENT_OFFSET)
        output_current_offset_trim_reg <= req_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cal_vout_o           <= 16'h0000;
      cal_input_voltage_o  <= 16'h0000;
      cal_output_current_o <= 16'h0000;
    end else begin
      cal_vout_o <= calibrate(raw_vout_i, vout_readback_gain_reg,
                              vout_readback_offset_reg);
      cal_input_voltage_o <= calibrate(raw_input_voltage_i, vin_readback_gain_reg,
                                       vin_readback_offset_reg);
      cal_output_current_o <= calibrate(raw_output_current_i, output_current_gain_trim_reg,
                                        output_current_offset_trim_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration bytes and the serial block.

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      alert_and_pin_assign_reg <= mfr_cfg_pkg::ALERT_PIN_RESET[4:0];
      onoff_combine_logic_reg  <= mfr_cfg_pkg::COMB_RESET;
      power_ok_polarity_reg    <= mfr_cfg_pkg::PG_POL_RESET;
    end else if (commit) begin
      if (req_code_i == mfr_cfg_pkg::CMD_ALERT_PIN)
        alert_and_pin_assign_reg <= req_wdata_i[4:0];
      if (req_code_i == mfr_cfg_pkg::CMD_ONOFF_COMBINE)
        onoff_combine_logic_reg <= req_wdata_i[1:0];
      if (req_code_i == mfr_cfg_pkg::CMD_POWER_OK_POL)
        power_ok_polarity_reg <= req_wdata_i[0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      module_date_loc_serial_reg <= mfr_cfg_pkg::BLK_RESET;
    end else if (commit && req_code_i == mfr_cfg_pkg::CMD_DATE_LOC_SER) begin
      module_date_loc_serial_reg <= blk_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins. The first flip-flop of each pair feeds only the second.

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      first_pin_sync_reg  <= 2'h0;
      second_pin_sync_reg <= 2'h0;
    end else begin
      first_pin_sync_reg  <= {first_pin_sync_reg[0], first_config_pin_i};
      second_pin_sync_reg <= {second_pin_sync_reg[0], second_config_pin_i};
    end
  end

  logic [3:0] map_code;
  logic       sec_pin_level;
  logic       sec_mapped;
  logic       sec_request;
  logic       pg_level;

  assign map_code   = alert_and_pin_assign_reg[3:0];
  assign ara_only_o = alert_and_pin_assign_reg[mfr_cfg_pkg::ARA_BIT];
  assign first_pin_is_trim_o = (map_code != mfr_cfg_pkg::PIN_ONOFF_PG);

  always_comb begin
    sec_mapped    = 1'b1;
    sec_pin_level = first_pin_sync_reg[1];
    unique case (map_code)
      mfr_cfg_pkg::PIN_ONOFF_PG:   sec_pin_level = first_pin_sync_reg[1];
      mfr_cfg_pkg::PIN_TRIM_ONOFF: sec_pin_level = second_pin_sync_reg[1];
      default:                     sec_mapped    = 1'b0;
    endcase
  end

  // An unmapped secondary input cannot hold the output off.
  assign sec_request = !sec_mapped
                    || (onoff_combine_logic_reg[mfr_cfg_pkg::COMB_POL_BIT]
                        ? sec_pin_level : !sec_pin_level);
  assign output_enable_o = primary_onoff_req_i
                        && (!onoff_combine_logic_reg[mfr_cfg_pkg::COMB_AND_BIT]
                            || sec_request);

  assign pg_level = power_ok_polarity_reg ? power_ok_i : !power_ok_i;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      second_config_pin_o    <= 1'b0;
      second_config_pin_oe_o <= 1'b0;
    end else begin
      second_config_pin_o    <= pg_level;
      second_config_pin_oe_o <= (map_code != mfr_cfg_pkg::PIN_TRIM_ONOFF);
    end
  end

  assign module_designation_o = {isolated_unit_i, designation_low_i};

endmodule

`default_nettype wire

// ===== sim/mfr_cfg_properties.sv
// Purpose: Port-level assertions for the manufacturer configuration register bank.
// Assumes: A request is taken at a rising edge and answered one cycle later.
// Notes:   Refusals are judged by the invalid data pulse that rides with the ack.
`timescale 1ns/10ps
`default_nettype none
module mfr_cfg_properties (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        req_valid_i,
  input wire logic        req_write_i,
  input wire logic [7:0]  req_code_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [7:0]  blk_wcount_i,
  input wire logic        write_protect_bit_i,
  input wire logic        droop_variant_i,
  input wire logic        ack_o,
  input wire logic        invalid_data_o,
  input wire logic [15:0] rd_data_o,
  input wire logic        ara_only_o,
  input wire logic        first_pin_is_trim_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic       take_wr;
  logic       take_rd;
  logic       is_gain;
  logic       is_cal;
  logic       gain_ok;
  logic       pin_ok;
  logic [4:0] exp_field;
  logic [3:0] pin_code;
  assign take_wr = req_valid_i && req_write_i && !srst_i;
  assign take_rd = req_valid_i && !req_write_i && !srst_i;
  assign is_gain = req_code_i inside {8'hd1, 8'hd3, 8'hd6};
  assign is_cal = is_gain || (req_code_i inside {8'hd2, 8'hd4, 8'hd7, 8'hf0});
  assign gain_ok = req_wdata_i >= mfr_cfg_pkg::GAIN_MIN && req_wdata_i <= mfr_cfg_pkg::GAIN_MAX;
  assign pin_code = req_wdata_i[3:0];
  assign pin_ok = req_wdata_i[7:5] == 3'h0 && (pin_code == 4'h0 || (!droop_variant_i
                  && pin_code <= 4'h2));
  assign exp_field = req_wdata_i[15:11];
  //////////////////////////////////////////////////////////////////////////////////////////////
  sequence s_refused;
    ack_o && invalid_data_o;
  endsequence
  sequence s_accepted;
    ack_o && !invalid_data_o;
  endsequence
  // The exponent is judged only when unlocked, since the lock refuses on its own.
  property p_exponent(logic [7:0] code, logic [4:0] expv);
    take_wr && req_code_i == code && !write_protect_bit_i
      |=> ack_o && (invalid_data_o == ($past(exp_field) != expv));
  endproperty
  a_gain_span_check: assert property (take_wr && is_gain && !gain_ok |=> s_refused)
    else $error("Gain outside its span was accepted.");
  a_protect_blocks_writes: assert property (take_wr && is_cal && write_protect_bit_i
    |=> s_refused) else $error("Locked write was accepted.");
  a_vout_exp_check: assert property (p_exponent(8'hd2, 5'h14))
    else $error("Output voltage offset exponent misjudged.");
  a_vin_exp_check: assert property (p_exponent(8'hd4, 5'h1d))
    else $error("Input voltage offset exponent misjudged.");
  a_output_current_exp_check: assert property (p_exponent(8'hd7, 5'h1c))
    else $error("Output current offset exponent misjudged.");
  a_block_count_check: assert property (take_wr && req_code_i == 8'hf0
    && blk_wcount_i != mfr_cfg_pkg::BLK_COUNT |=> s_refused) else $error("Short block taken.");
  a_fw_bcd_digits: assert property (take_rd && req_code_i == 8'hdb |=> ack_o
    && rd_data_o[15:12] <= 4'h9 && rd_data_o[11:8] <= 4'h9 && rd_data_o[7:4] <= 4'h9
    && rd_data_o[3:0] <= 4'h9) else $error("Revision digit above nine.");
  a_ara_bit_follows: assert property (take_wr && req_code_i == 8'he0 && pin_ok
    |=> s_accepted ##0 ara_only_o == $past(req_wdata_i[4])) else $error("Alert bit lost.");
  a_pin_map_follows: assert property (take_wr && req_code_i == 8'he0 && pin_ok
    |=> first_pin_is_trim_o == ($past(pin_code) != 4'h0)) else $error("Pin map wrong.");
  a_droop_only_zero: assert property (take_wr && req_code_i == 8'he0 && droop_variant_i
    && pin_code != 4'h0 |=> s_refused) else $error("Droop variant took a pin code.");
endmodule
bind mfr_cfg_regs mfr_cfg_properties checker_i (
  .clock_i(clock_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
  .req_code_i(req_code_i), .req_wdata_i(req_wdata_i), .blk_wcount_i(blk_wcount_i),
  .write_protect_bit_i(write_protect_bit_i), .droop_variant_i(droop_variant_i), .ack_o(ack_o),
  .invalid_data_o(invalid_data_o), .rd_data_o(rd_data_o), .ara_only_o(ara_only_o),
  .first_pin_is_trim_o(first_pin_is_trim_o));
`default_nettype wire

// ===== sim/pmbus_host_model.sv
// Purpose: Host side of the command port, issuing one request at a time.
// Assumes: The device answers one cycle after it takes a request.
// Notes:   Released data lines show inverted values so stale data is never trusted.
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
  input  wire logic  clock_i,
  input  wire logic  ack_i,
  input  wire logic  invalid_data_i,
  input  wire logic  invalid_cmd_i,
  output logic       req_valid_o,
  output logic       req_write_o,
  output logic [7:0] req_code_o,
  output logic [15:0] req_wdata_o,
  output logic [95:0] blk_wdata_o,
  output logic [7:0] blk_wcount_o
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_code_o = 8'h00;
    req_wdata_o = 16'h0000;
    blk_wdata_o = 96'h0;
    blk_wcount_o = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                        input logic [95:0] b, input logic [7:0] n, output logic [2:0] r);
    @(negedge clock_i);
    req_valid_o = 1'b1;
    req_write_o = w;
    req_code_o = c;
    req_wdata_o = d;
    blk_wdata_o = b;
    blk_wcount_o = n;
    @(negedge clock_i);
    r = {ack_i, invalid_data_i, invalid_cmd_i};
    req_valid_o = 1'b0;
    req_code_o = ~c;
    req_wdata_o = ~d;
    blk_wdata_o = ~b;
  endtask
endmodule
`default_nettype wire

// ===== sim/pmbus_mfr_config_regs_bench.sv
// Purpose: Self-checking bench for the manufacturer configuration register bank.
// Assumes: Inputs change at the falling edge; answers are read one cycle on.
// Notes:   Raw readings are fixed, so calibrated values are easy to predict.
`timescale 1ns/10ps
`default_nettype none
module pmbus_mfr_config_regs_bench;
  localparam logic [2:0]  OK = 3'b100;
  localparam logic [2:0]  BAD = 3'b110;
  localparam logic [2:0]  UNK = 3'b101;
  localparam logic [31:0] RAW_V = 32'h1234;
  localparam logic [31:0] RAW_I = 32'h0567;
  localparam logic [31:0] RAW_C = 32'h0089;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        wp = 1'b0, droop = 1'b0, iso = 1'b0, prim = 1'b1, pg = 1'b1, pin1 = 1'b0;
  logic [95:0] blk = 96'h0;
  logic [7:0]  cnt = 8'h0c;
  int          failures = 0;
  int          check_count = 0;
  wire logic   valid, write, ack, inv_d, inv_c, ara, trim, pin2_o, pin2_oe, oen, pin2_wire;
  wire logic [7:0]  code, blk_wc, blk_rc;
  wire logic [15:0] wdata, rd_data, cal_v, cal_i, cal_c;
  wire logic [95:0] blk_wd, blk_rd;
  wire logic [5:0]  desig;
  // The second pin is an input only while the device leaves it undriven.
  assign pin2_wire = pin2_oe ? pin2_o : 1'b0;
  always #50 clock_i = ~clock_i;
  pmbus_host_model host (.clock_i(clock_i), .ack_i(ack), .invalid_data_i(inv_d),
    .invalid_cmd_i(inv_c), .req_valid_o(valid), .req_write_o(write), .req_code_o(code),
    .req_wdata_o(wdata), .blk_wdata_o(blk_wd), .blk_wcount_o(blk_wc));
  mfr_cfg_regs dut (.clock_i(clock_i), .srst_i(srst_i), .req_valid_i(valid),
    .req_write_i(write), .req_code_i(code), .req_wdata_i(wdata), .blk_wdata_i(blk_wd),
    .blk_wcount_i(blk_wc), .write_protect_bit_i(wp), .droop_variant_i(droop),
    .isolated_unit_i(iso), .designation_low_i(5'h0a), .primary_onoff_req_i(prim),
    .power_ok_i(pg), .raw_vout_i(RAW_V[15:0]), .raw_input_voltage_i(RAW_I[15:0]),
    .raw_output_current_i(RAW_C[15:0]), .first_config_pin_i(pin1),
    .second_config_pin_i(pin2_wire), .ack_o(ack), .invalid_data_o(inv_d), .invalid_cmd_o(inv_c),
    .rd_data_o(rd_data), .blk_rdata_o(blk_rd), .blk_rcount_o(blk_rc), .ara_only_o(ara),
    .first_pin_is_trim_o(trim), .second_config_pin_o(pin2_o), .second_config_pin_oe_o(pin2_oe),
    .output_enable_o(oen), .module_designation_o(desig), .cal_vout_o(cal_v),
    .cal_input_voltage_o(cal_i), .cal_output_current_o(cal_c));
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [95:0] e, input logic [95:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bit_ck(input string what, input logic e, input logic g);
    check(what, {95'h0, e}, {95'h0, g});
  endtask
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic [2:0] er);
    logic [2:0] r;
    host.access(w, c, d, blk, cnt, r);
    check("response", {93'h0, er}, {93'h0, r});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    xfer(1'b0, c, 16'h0000, OK);
    check("rd_data_o", {80'h0, e}, {80'h0, rd_data});
  endtask
  task automatic t_reset();
    logic [7:0]  c [9] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7, 8'he0, 8'he1, 8'he2};
    logic [15:0] e [9] = '{16'h2000, 16'ha000, 16'h2000, 16'he800, 16'h2000, 16'he000,
                           16'h0000, 16'h0000, 16'h0001};
    for (int k = 0; k < 9; k++) rd(c[k], e[k]);
    check("cal_vout_o", {80'h0, RAW_V[15:0]}, {80'h0, cal_v});
    check("cal_input_voltage_o", {80'h0, RAW_I[15:0]}, {80'h0, cal_i});
    check("module_designation_o", {90'h0, 6'h0a}, {90'h0, desig});
    iso = 1'b1;
    @(negedge clock_i);
    check("module_designation_o", {90'h0, 6'h2a}, {90'h0, desig});
    $display("test reset done");
  endtask
  task automatic t_cal();
    logic [7:0] c [3] = '{8'hd1, 8'hd3, 8'hd6};
    logic [7:0] o [3] = '{8'hd2, 8'hd4, 8'hd7};
    logic [4:0] x [3] = '{5'h14, 5'h1d, 5'h1c};
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, c[k], 16'h2667, BAD);
      xfer(1'b1, c[k], 16'h1998, BAD);
      xfer(1'b1, c[k], 16'h2666, OK);
      rd(c[k], 16'h2666);
      xfer(1'b1, c[k], 16'h1999, OK);
      xfer(1'b1, o[k], {x[k] + 5'h01, 11'h005}, BAD);
      xfer(1'b1, o[k], {x[k], 11'h005}, OK);
      rd(o[k], {x[k], 11'h005});
    end
    check("cal_vout_o", {80'h0, 16'(((RAW_V * 32'h1999) >> 13) + 32'h5)}, {80'h0, cal_v});
    check("cal_input_voltage_o", {80'h0, 16'(((RAW_I * 32'h1999) >> 13) + 32'h5)},
          {80'h0, cal_i});
    check("cal_output_current_o", {80'h0, 16'(((RAW_C * 32'h1999) >> 13) + 32'h5)},
          {80'h0, cal_c});
    $display("test calibration done");
  endtask
  task automatic t_protect();
    wp = 1'b1;
    blk = 96'h0123_4567_89ab_cdef_0246_8ace;
    xfer(1'b1, 8'hd1, 16'h2000, BAD);
    xfer(1'b1, 8'hd3, 16'h2000, BAD);
    xfer(1'b1, 8'hd6, 16'h2000, BAD);
    xfer(1'b1, 8'hd4, 16'he800, BAD);
    xfer(1'b1, 8'hf0, 16'h0000, BAD);
    rd(8'hd1, 16'h1999);
    wp = 1'b0;
    cnt = 8'h0b;
    xfer(1'b1, 8'hf0, 16'h0000, BAD);
    cnt = 8'h0c;
    xfer(1'b1, 8'hf0, 16'h0000, OK);
    rd(8'hf0, 16'h0000);
    check("blk_rdata_o", blk, blk_rd);
    check("blk_rcount_o", {88'h0, 8'h0c}, {88'h0, blk_rc});
    $display("test protect done");
  endtask
  task automatic t_fw();
    rd(8'hdb, mfr_cfg_pkg::FW_REV_VALUE);
    for (int k = 0; k < 4; k++) bit_ck("bcd digit", 1'b1, rd_data[4*k +: 4] <= 4'h9);
    xfer(1'b1, 8'hdb, 16'h9999, BAD);
    rd(8'hdb, mfr_cfg_pkg::FW_REV_VALUE);
    xfer(1'b0, 8'h55, 16'h0000, UNK);
    $display("test revision done");
  endtask
  task automatic t_pins();
    xfer(1'b1, 8'he0, 16'h0011, OK);
    bit_ck("ara_only_o", 1'b1, ara);
    bit_ck("first_pin_is_trim_o", 1'b1, trim);
    xfer(1'b1, 8'he0, 16'h0002, OK);
    @(negedge clock_i);
    bit_ck("ara_only_o", 1'b0, ara);
    bit_ck("second_config_pin_oe_o", 1'b0, pin2_oe);
    xfer(1'b1, 8'he1, 16'h0003, OK);
    pin1 = 1'b1;
    repeat (3) @(negedge clock_i);
    bit_ck("output_enable_o", 1'b0, oen);
    xfer(1'b1, 8'he0, 16'h0003, BAD);
    xfer(1'b1, 8'he0, 16'h0020, BAD);
    droop = 1'b1;
    xfer(1'b1, 8'he0, 16'h0001, BAD);
    xfer(1'b1, 8'he0, 16'h0000, OK);
    rd(8'he0, 16'h0000);
    bit_ck("first_pin_is_trim_o", 1'b0, trim);
    bit_ck("second_config_pin_oe_o", 1'b1, pin2_oe);
    $display("test pins done");
  endtask
  task automatic t_onoff_pg();
    xfer(1'b1, 8'he1, 16'h00ff, OK);
    rd(8'he1, 16'h0003);
    pin1 = 1'b1;
    repeat (3) @(negedge clock_i);
    bit_ck("output_enable_o", 1'b1, oen);
    pin1 = 1'b0;
    repeat (3) @(negedge clock_i);
    bit_ck("output_enable_o", 1'b0, oen);
    xfer(1'b1, 8'he1, 16'h0002, OK);
    bit_ck("output_enable_o", 1'b1, oen);
    prim = 1'b0;
    @(negedge clock_i);
    bit_ck("output_enable_o", 1'b0, oen);
    prim = 1'b1;
    pin1 = 1'b1;
    xfer(1'b1, 8'he1, 16'h0000, OK);
    repeat (3) @(negedge clock_i);
    bit_ck("output_enable_o", 1'b1, oen);
    xfer(1'b1, 8'he2, 16'h00fe, OK);
    rd(8'he2, 16'h0000);
    bit_ck("second_config_pin_o", 1'b0, pin2_o);
    pg = 1'b0;
    @(negedge clock_i);
    bit_ck("second_config_pin_o", 1'b1, pin2_o);
    xfer(1'b1, 8'he2, 16'h0001, OK);
    @(negedge clock_i);
    bit_ck("second_config_pin_o", 1'b0, pin2_o);
    $display("test on off and power good done");
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock_i);
    srst_i = 1'b0;
    t_reset();
    t_cal();
    t_protect();
    t_fw();
    t_pins();
    t_onoff_pg();
    complete_run();
  end
  // About one hundred sixty cycles are needed; the limit leaves wide margin.
  initial begin
    #500000;
    failures++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
`default_nettype wire
